//--- pkg/led_sink_map.vh
`ifndef LED_SINK_MAP_VH
`define LED_SINK_MAP_VH

// register offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STAT    8'h08
`define OFS_IRQ_MASK    8'h0C
`define OFS_SHIFT       8'h10
`define OFS_LATCH       8'h14
`define OFS_W           8

// control fields
`define CTRL_WDOG_EN    0
`define CTRL_W          1
`define CTRL_RESET      1'h1

// status fields
`define ST_SHIFT_LSB    0
`define ST_LATCH_LSB    8
`define ST_PINS_LSB     16
`define ST_HOLD_BIT     20
`define ST_FAULT_BIT    21

// interrupt fields
`define IRQ_WDOG        0
`define IRQ_FAULT       1
`define IRQ_LOAD        2
`define IRQ_W           3
`define IRQ_RESET       3'h0

// serial word
`define WORD_W          8
`define WORD_MSB        7
`define FLAG_HI_BIT     6
`define FLAG_LO_BIT     5
`define BYTE_ZERO       8'h00
`define WORD_ZERO       32'h0000_0000

// link inputs after synchronising
`define PIN_CLK         0
`define PIN_DIN         1
`define PIN_LOAD        2
`define PIN_BLANK       3
`define PIN_W           4

// watchdog timing
`define WDOG_TIME_MS    1000
`define HCLK_KHZ        20000
// one second of idle link at 20 mhz, sized to the counter
`define WDOG_CYCLES     25'h131_2d00
`define WDOG_CNT_W      25
`define WDOG_CNT_ZERO   25'h000_0000
`define WDOG_CNT_ONE    25'h000_0001

// bus
`define HTRANS_BUSY     1

`endif

//--- verilog/inactivity_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "led_sink_map.vh"

module inactivity_timer #(
    parameter [`WDOG_CNT_W-1:0] LIMIT = `WDOG_CYCLES
) (
    // clock and reset
    input  wire                   hclk,
    input  wire                   hresetn,
    // control
    input  wire                   enable,
    input  wire                   activity,
    // result
    output reg                    timeout
);

    reg [`WDOG_CNT_W-1:0] count_reg;

    ////////////////////////////////////////////////////////////////////////
    // count of idle cycles, cleared on activity, while disabled and at timeout
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= `WDOG_CNT_ZERO;
            timeout   <= 1'b0;
        end else if (!enable || activity) begin
            count_reg <= `WDOG_CNT_ZERO;
            timeout   <= 1'b0;
        end else if (count_reg >= LIMIT - `WDOG_CNT_ONE) begin
            count_reg <= `WDOG_CNT_ZERO;
            timeout   <= 1'b1;
        end else begin
            count_reg <= count_reg + `WDOG_CNT_ONE;
            timeout   <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- verilog/led_sink_shift_latch_watchdog.v
// Operation
// - power-up reset clears the link state: sinks off, serial output low; the watchdog enable resets to one.
// - one serial word is eight bits, numbered zero to seven.
// - each serial clock rise shifts sampled input into the 8-bit register.
// - latch follows the fault-free copy of the stream while load high, holds after its fall.
// - load rise overwrites bits six and five only with fault status.
// - fault status leaves on serial output during the next word.
// - blanking high turns all sinks off, latch kept; low follows latch.
// - shifting and latching ignore the blanking input level.
// - serial output is the last stage, updated on serial clock rise.
// - one second with no clock, data or load transition clears latch.
// - watchdog timeout leaves the shift register untouched.
// - after timeout sinks stay off until new data loads; no lockup.
// - renewed activity restarts the inactivity timer, no recovery needed.
// - fault bits both high if any lit output is open, else low.
`timescale 1ns/1ps
`default_nettype none
`include "led_sink_map.vh"

module led_sink_shift_latch_watchdog #(
    parameter [`WDOG_CNT_W-1:0] WDOG_CYCLES = `WDOG_CYCLES
) (
    // clock and reset
    input  wire                   hclk,
    input  wire                   hresetn,
    // ahb-lite slave
    input  wire                   hsel,
    input  wire [31:0]            haddr,
    input  wire [1:0]             htrans,
    input  wire                   hwrite,
    input  wire [2:0]             hsize,
    input  wire [31:0]            hwdata,
    input  wire                   hready,
    output reg  [31:0]            hrdata,
    output reg                    hreadyout,
    output reg                    hresp,
    // serial link
    input  wire                   serial_clk,
    input  wire                   serial_din,
    input  wire                   latch_load,
    input  wire                   output_blank,
    output reg                    serial_dout,
    // open-led sense
    input  wire [7:0]             open_fault,
    // sink outputs, open drain
    input  wire [7:0]             sink_outputs_in,
    output reg  [7:0]             sink_outputs_out,
    output reg  [7:0]             sink_outputs_oe_n,
    // interrupt
    output reg                    irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    reg  [`PIN_W-1:0]     pin_meta_reg;
    reg  [`PIN_W-1:0]     pin_sync_reg;
    reg  [`PIN_W-1:0]     pin_prev_reg;
    reg  [7:0]            fault_meta_reg;
    reg  [7:0]            fault_sync_reg;
    reg  [7:0]            shift_reg;
    reg  [7:0]            shift_next;
    reg  [7:0]            shifted;
    reg  [7:0]            data_reg;
    reg  [7:0]            data_next;
    reg  [7:0]            latch_reg;
    reg  [7:0]            latch_next;
    reg                   hold_reg;
    reg                   fault_seen_reg;
    reg  [`CTRL_W-1:0]    ctrl_reg;
    reg  [`IRQ_W-1:0]     irq_stat_reg;
    reg  [`IRQ_W-1:0]     irq_stat_next;
    reg  [`IRQ_W-1:0]     irq_mask_reg;
    reg  [`IRQ_W-1:0]     irq_events;
    reg  [`IRQ_W-1:0]     irq_clear;
    reg                   wr_pend_reg;
    reg  [`OFS_W-1:0]     wr_addr_reg;
    wire                  clk_rise;
    wire                  load_rise;
    wire                  load_high;
    wire                  blank_high;
    wire                  activity;
    wire                  fault_any;
    wire                  timeout;
    wire                  addr_phase;
    wire [3:0]            pin_edges;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function hit;
        input [`OFS_W-1:0] addr;
        input [`OFS_W-1:0] ofs;
        begin
            hit = (addr[`OFS_W-1:2] == ofs[`OFS_W-1:2]);
        end
    endfunction

    function [7:0] shift_in;
        input [7:0] word;
        input       bit_in;
        begin
            shift_in = {word[`WORD_MSB-1:0], bit_in};
        end
    endfunction

    function [31:0] read_word;
        input [`OFS_W-1:0] addr;
        begin
            read_word = `WORD_ZERO;
            if (hit(addr, `OFS_CTRL)) begin
                read_word[`CTRL_W-1:0] = ctrl_reg;
            end
            if (hit(addr, `OFS_STATUS)) begin
                read_word[`ST_SHIFT_LSB +: `WORD_W] = shift_reg;
                read_word[`ST_LATCH_LSB +: `WORD_W] = latch_reg;
                read_word[`ST_PINS_LSB +: `PIN_W]   = pin_sync_reg;
                read_word[`ST_HOLD_BIT]             = hold_reg;
                read_word[`ST_FAULT_BIT]            = fault_seen_reg;
            end
            if (hit(addr, `OFS_IRQ_STAT)) begin
                read_word[`IRQ_W-1:0] = irq_stat_reg;
            end
            if (hit(addr, `OFS_IRQ_MASK)) begin
                read_word[`IRQ_W-1:0] = irq_mask_reg;
            end
            if (hit(addr, `OFS_SHIFT)) begin
                read_word[`WORD_W-1:0] = shift_reg;
            end
            if (hit(addr, `OFS_LATCH)) begin
                read_word[`WORD_W-1:0] = latch_reg;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, edges found on the second stage only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_reg   <= {`PIN_W{1'b0}};
            pin_sync_reg   <= {`PIN_W{1'b0}};
            pin_prev_reg   <= {`PIN_W{1'b0}};
            fault_meta_reg <= `BYTE_ZERO;
            fault_sync_reg <= `BYTE_ZERO;
        end else begin
            pin_meta_reg   <= {output_blank, latch_load, serial_din, serial_clk};
            pin_sync_reg   <= pin_meta_reg;
            pin_prev_reg   <= pin_sync_reg;
            fault_meta_reg <= open_fault;
            fault_sync_reg <= fault_meta_reg;
        end
    end

    assign pin_edges  = pin_sync_reg ^ pin_prev_reg;
    assign clk_rise   = pin_sync_reg[`PIN_CLK] & ~pin_prev_reg[`PIN_CLK];
    assign load_rise  = pin_sync_reg[`PIN_LOAD] & ~pin_prev_reg[`PIN_LOAD];
    assign load_high  = pin_sync_reg[`PIN_LOAD];
    assign blank_high = pin_sync_reg[`PIN_BLANK];
    // watched inputs: clock, data and load, not blanking
    assign activity   = pin_edges[`PIN_CLK] | pin_edges[`PIN_DIN] |
                        pin_edges[`PIN_LOAD];

    ////////////////////////////////////////////////////////////////////////
    // shift register with fault insertion
    // display copy of the stream, fault bits kept out of the latch
    always @* begin
        shifted   = shift_reg;
        data_next = data_reg;
        if (clk_rise) begin
            shifted   = shift_in(shift_reg, pin_sync_reg[`PIN_DIN]);
            data_next = shift_in(data_reg, pin_sync_reg[`PIN_DIN]);
        end
    end

    // lit outputs are those the new latch data turns on
    assign fault_any = |(fault_sync_reg & data_next);

    always @* begin
        shift_next = shifted;
        if (load_rise) begin
            shift_next[`FLAG_HI_BIT] = fault_any;
            shift_next[`FLAG_LO_BIT] = fault_any;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg   <= `BYTE_ZERO;
            data_reg    <= `BYTE_ZERO;
            serial_dout <= 1'b0;
        end else begin
            shift_reg   <= shift_next;
            data_reg    <= data_next;
            serial_dout <= shift_next[`WORD_MSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latch and watchdog hold
    always @* begin
        latch_next = latch_reg;
        if (timeout) begin
            latch_next = `BYTE_ZERO;
        end else if (load_high && !hold_reg) begin
            latch_next = data_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_reg      <= `BYTE_ZERO;
            hold_reg       <= 1'b0;
            fault_seen_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            if (timeout) begin
                hold_reg <= 1'b1;
            end else if (activity) begin
                hold_reg <= 1'b0;
            end
            if (load_rise) begin
                fault_seen_reg <= fault_any;
            end
        end
    end

    inactivity_timer #(
        .LIMIT    (WDOG_CYCLES)
    ) u_timer (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .enable   (ctrl_reg[`CTRL_WDOG_EN]),
        .activity (activity),
        .timeout  (timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // sink drivers: open drain, enable low while sinking
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sink_outputs_out  <= `BYTE_ZERO;
            sink_outputs_oe_n <= ~`BYTE_ZERO;
        end else begin
            sink_outputs_out  <= `BYTE_ZERO;
            // one sinks current, zero or blanking releases the pin
            sink_outputs_oe_n <= ~(latch_next & {`WORD_W{~blank_high}});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status
    always @* begin
        irq_events                = `IRQ_RESET;
        irq_events[`IRQ_WDOG]     = timeout;
        irq_events[`IRQ_FAULT]    = load_rise & fault_any;
        irq_events[`IRQ_LOAD]     = load_rise;
        irq_clear                 = `IRQ_RESET;
        if (wr_pend_reg && hit(wr_addr_reg, `OFS_IRQ_STAT)) begin
            irq_clear = hwdata[`IRQ_W-1:0];
        end
        // set wins over clear
        irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= `IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq <= |(irq_stat_next & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states, always okay
    assign addr_phase = hsel & hready & htrans[`HTRANS_BUSY];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata       <= `WORD_ZERO;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= `BYTE_ZERO;
            ctrl_reg     <= `CTRL_RESET;
            irq_mask_reg <= `IRQ_RESET;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wr_pend_reg <= addr_phase & hwrite;
                wr_addr_reg <= haddr[`OFS_W-1:0];
            end
            if (addr_phase && !hwrite) begin
                hrdata <= read_word(haddr[`OFS_W-1:0]);
            end else begin
                hrdata <= `WORD_ZERO;
            end
            if (wr_pend_reg && hit(wr_addr_reg, `OFS_CTRL)) begin
                ctrl_reg <= hwdata[`CTRL_W-1:0];
            end
            if (wr_pend_reg && hit(wr_addr_reg, `OFS_IRQ_MASK)) begin
                irq_mask_reg <= hwdata[`IRQ_W-1:0];
            end
        end
    end

endmodule
`default_nettype wire

//--- sim/led_sink_properties.sv
`timescale 1ns/1ps
`default_nettype none
module led_sink_properties #(
    parameter [24:0] WDOG_CYCLES = 25'h000_00c8
) (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // link and sinks
    input wire logic        serial_clk,
    input wire logic        serial_din,
    input wire logic        latch_load,
    input wire logic        output_blank,
    input wire logic        serial_dout,
    input wire logic [7:0]  sink_outputs_out,
    input wire logic [7:0]  sink_outputs_oe_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0]  pins_reg;
    logic [25:0] idle_reg;
    // cycles since clock, data or load last moved
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_reg <= 3'h0;
            idle_reg <= 26'h000_0000;
        end else begin
            pins_reg <= {serial_clk, serial_din, latch_load};
            if (pins_reg != {serial_clk, serial_din, latch_load})
                idle_reg <= 26'h000_0000;
            else
                idle_reg <= idle_reg + 26'h000_0001;
        end
    end
    a_reset_idle:
        assert property ($rose(hresetn) |-> sink_outputs_oe_n == 8'hff && !serial_dout)
        else $error("outputs not idle after reset");
    a_ready_okay:
        assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    a_sink_drive_low:
        assert property (sink_outputs_out == 8'h00) else $error("sink drives high");
    a_rdata_idle:
        assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data outside read phase");
    a_blank_all_off:
        assert property (output_blank [*5] |-> sink_outputs_oe_n == 8'hff)
        else $error("sink on while blanked");
    a_latch_held:
        assert property ((!latch_load && !output_blank) [*7]
            |-> $stable(sink_outputs_oe_n) || sink_outputs_oe_n == 8'hff)
        else $error("latch moved while load low");
    a_dout_on_clock:
        assert property ($changed(serial_dout) |-> idle_reg < 26'h000_0008)
        else $error("serial out moved without clock");
    a_wdog_clears:
        assert property (idle_reg >= {1'b0, WDOG_CYCLES} + 26'h000_0008
            |-> sink_outputs_oe_n == 8'hff)
        else $error("watchdog did not clear latch");
endmodule
bind led_sink_shift_latch_watchdog led_sink_properties #(.WDOG_CYCLES(WDOG_CYCLES)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_clk(serial_clk), .serial_din(serial_din), .latch_load(latch_load),
    .output_blank(output_blank), .serial_dout(serial_dout),
    .sink_outputs_out(sink_outputs_out), .sink_outputs_oe_n(sink_outputs_oe_n));
`default_nettype wire

//--- sim/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // clock
    input  wire logic      hclk,
    // link pins
    output var logic       serial_clk,
    output var logic       serial_din,
    output var logic       latch_load,
    output var logic       output_blank,
    input  wire logic      serial_dout,
    // word returned on serial out
    output var logic [7:0] rx_word
);
    initial begin
        serial_clk = 1'b0;
        serial_din = 1'b0;
        latch_load = 1'b0;
        output_blank = 1'b0;
        rx_word = 8'h00;
    end
    // 400 ns clock, still between frames
    task automatic send_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            serial_din <= w[i];
            repeat (4) @(posedge hclk);
            rx_word <= {rx_word[6:0], serial_dout};
            serial_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            serial_clk <= 1'b0;
        end
        repeat (4) @(posedge hclk);
    endtask
    task automatic pulse_load;
        latch_load <= 1'b1;
        repeat (8) @(posedge hclk);
        latch_load <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
    task automatic set_blank(input logic b);
        output_blank <= b;
        repeat (8) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic        serial_clk;
    logic        serial_din;
    logic        latch_load;
    logic        output_blank;
    logic        serial_dout;
    logic        irq;
    logic [7:0]  open_fault;
    logic [7:0]  oe_n;
    logic [7:0]  rx_word;
    int          bad_count;
    int          tests_run;
    led_sink_shift_latch_watchdog #(.WDOG_CYCLES(25'h000_00c8)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .serial_clk(serial_clk), .serial_din(serial_din), .latch_load(latch_load),
        .output_blank(output_blank), .serial_dout(serial_dout), .open_fault(open_fault),
        .sink_outputs_in(oe_n), .sink_outputs_out(), .sink_outputs_oe_n(oe_n), .irq(irq));
    host_link_model host (
        .hclk(hclk), .serial_clk(serial_clk), .serial_din(serial_din),
        .latch_load(latch_load), .output_blank(output_blank),
        .serial_dout(serial_dout), .rx_word(rx_word));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // single ahb transfer, waits on ready
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do begin
            @(posedge hclk);
        end while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (!hreadyout);
        rd = hrdata;
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        end_of_test;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        open_fault = 8'h00;
        bad_count = 0;
        tests_run = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({23'h0, serial_dout, oe_n}, 32'h0000_00ff);
        host.send_word(8'ha5);
        host.pulse_load;
        chk({24'h0, oe_n}, 32'h0000_005a);
        ahb(1'b0, 32'h0000_0014, 32'h0000_0000);
        chk(rd, 32'h0000_00a5);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk(rd, 32'h0000_0085);
        chk({31'h0, irq}, 32'h0000_0000);
        // fault on a lit output, fault interrupt unmasked
        ahb(1'b1, 32'h0000_000c, 32'h0000_0002);
        open_fault <= 8'h04;
        host.send_word(8'h3c);
        chk({24'h0, rx_word}, 32'h0000_0085);
        host.pulse_load;
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk(rd, 32'h0000_007c);
        chk({31'h0, irq}, 32'h0000_0001);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(rd, 32'h0000_0006);
        ahb(1'b1, 32'h0000_0008, 32'h0000_0006);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0000_0000);
        // update while blanked
        open_fault <= 8'h00;
        host.set_blank(1'b1);
        chk({24'h0, oe_n}, 32'h0000_00ff);
        host.send_word(8'hff);
        host.pulse_load;
        chk({24'h0, oe_n}, 32'h0000_00ff);
        chk({24'h0, rx_word}, 32'h0000_007c);
        host.set_blank(1'b0);
        chk({24'h0, oe_n}, 32'h0000_0000);
        // idle link until the watchdog fires
        repeat (260) @(posedge hclk);
        chk({24'h0, oe_n}, 32'h0000_00ff);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk(rd, 32'h0000_009f);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        host.send_word(8'h0f);
        chk({24'h0, oe_n}, 32'h0000_00ff);
        host.pulse_load;
        chk({24'h0, oe_n}, 32'h0000_00f0);
        // status: shift and latch 0f, din high, no hold, no fault
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk(rd, 32'h0002_0f0f);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        end_of_test;
    end
endmodule
`default_nettype wire
